// ### src/pst_defines.vh
// Purpose: constants for the program sequencer core
// Assumes: one instruction cycle per clock_i enable-free cycle
// Notes: depth and width fixed per variant build
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH
`define PST_PC_W 13
`define PST_BANK_W 2
`define PST_ADDR_W 15
`define PST_WORD_W 16
`define PST_STACK_DEPTH 16
`define PST_SP_W 4
`define PST_CNT_W 5
`define PST_RESET_VECTOR 15'h0000
`define PST_PAGE_W 8
// op codes presented by the decoder
`define PST_OP_W 4
`define PST_OP_SEQ 4'h0
`define PST_OP_JMP 4'h1
`define PST_OP_CALL 4'h2
`define PST_OP_RET 4'h3
`define PST_OP_IRET 4'h4
`define PST_OP_SKIP 4'h5
`define PST_OP_PCLWR 4'h6
`define PST_OP_TRD 4'h7
`define PST_OP_TRDL 4'h8
`define PST_OP_TRDF 4'h9
`define PST_OP_TRDFL 4'ha
`define PST_OP_ALU 4'hb
// sequencer states
`define PST_ST_W 2
`define PST_ST_RUN 2'h0
`define PST_ST_DUMMY 2'h1
`define PST_ST_TABLE 2'h2
// status flag positions
`define PST_FLAG_C 0
`define PST_FLAG_AC 1
`define PST_FLAG_Z 2
`define PST_FLAG_OV 3
`endif

// ### src/pst_sequencer.v
// Purpose: program counter, return stack, table read and status update
// Assumes: one instruction per clock, decoder supplies op and operands
// Notes: stack is 16 deep for the largest variant
`include "pst_defines.vh"
// Notes on behaviour
// RL1: counter increments for sequential instructions
// RL2: bank select bits extend address upward
// RL3: only low byte visible to software
// RL4: jumps calls interrupts reset load target
// RL5: met skip discards prefetch, dummy cycle
// RL6: low byte write jumps within page
// RL7: low byte write adds dummy cycle
// RL8: stack hidden from software entirely
// RL9: call or interrupt pushes counter
// RL10: return pops and restores counter
// RL11: reset sets stack pointer to top
// RL12: full stack defers interrupt acknowledge
// RL13: call on full stack overflows
// RL14: stack depth per variant parameter; code fixes it at 16 for all variants
// RL15: alu ops write result, update flags
// RL16: reset fetch starts at zero
// RL17: table read splits word low/high
// RL18: unused high bits read zero
// RL19: table instructions take two cycles
// RL20: page read uses high pointer page
// RL21: short forms sector zero only
// RL22: software guards latch around interrupts
// RL23: each read overwrites high latch
module pst_sequencer (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // decoder
   input wire instr_valid_i,
   input wire [`PST_OP_W-1:0] op_i,
   input wire [`PST_ADDR_W-1:0] target_i,
   input wire skip_met_i,
   input wire [7:0] pcl_wdata_i,
   input wire [7:0] dest_addr_i,
   input wire [1:0] dest_sector_i,
   input wire [7:0] alu_result_i,
   input wire [3:0] alu_flags_i,
   input wire [3:0] alu_flag_mask_i,
   input wire [7:0] alu_dest_addr_i,
   input wire [1:0] alu_dest_sector_i,
   // table pointers and bank select
   input wire [7:0] table_ptr_low_i,
   input wire [7:0] table_ptr_high_i,
   input wire [`PST_BANK_W-1:0] code_bank_select_i,
   input wire [`PST_WORD_W-1:0] word_width_mask_i,
   // interrupt request logic
   input wire irq_req_i,
   input wire [`PST_ADDR_W-1:0] irq_vector_i,
   // program memory
   output reg [`PST_ADDR_W-1:0] fetch_addr_o,
   output reg fetch_valid_o,
   input wire [`PST_WORD_W-1:0] prog_word_i,
   // data memory write port
   output reg dmem_we_o,
   output reg [7:0] dmem_addr_o,
   output reg [1:0] dmem_sector_o,
   output reg [7:0] dmem_wdata_o,
   // software visible state
   output reg [7:0] pc_low_byte_o,
   output reg [7:0] table_high_latch_o,
   output reg [3:0] status_o,
   output reg irq_ack_o,
   output reg stall_o,
   output reg stack_full_o
);
   reg [`PST_PC_W-1:0] pc_ff;
   reg [`PST_BANK_W-1:0] bank_ff;
   reg [1:0] state_ff;
   reg [`PST_ADDR_W-1:0] table_addr_ff;
   reg [7:0] table_dest_ff;
   reg [1:0] table_sector_ff;
   reg [`PST_PC_W-1:0] nxt_pc;
   reg [`PST_BANK_W-1:0] nxt_bank;
   reg [1:0] nxt_state;
   reg push;
   reg pop;
   reg [`PST_ADDR_W-1:0] push_data;
   reg take_irq;
   reg start_table;
   reg [`PST_ADDR_W-1:0] nxt_table_addr;
   wire [`PST_ADDR_W-1:0] top;
   wire full;
   wire [`PST_ADDR_W-1:0] cur_addr;
   wire [`PST_PC_W-1:0] pc_inc;
   wire [`PST_WORD_W-1:0] masked_word;
   wire is_table;
   wire is_last;
   wire is_far;
   wire alu_take;
   wire table_beat;
   assign cur_addr = {bank_ff, pc_ff};
   // RL1: sequential advance
   assign pc_inc = pc_ff + 13'h0001;
   assign is_table = (op_i == `PST_OP_TRD) || (op_i == `PST_OP_TRDL) ||
                     (op_i == `PST_OP_TRDF) || (op_i == `PST_OP_TRDFL);
   assign is_last = (op_i == `PST_OP_TRDL) || (op_i == `PST_OP_TRDFL);
   assign is_far = (op_i == `PST_OP_TRDF) || (op_i == `PST_OP_TRDFL);
   // RL18: bits past word width zeroed
   assign masked_word = prog_word_i & word_width_mask_i;

   // a taken interrupt drops the instruction, so no write-back
   assign alu_take = (state_ff == `PST_ST_RUN) && !take_irq && instr_valid_i && (op_i == `PST_OP_ALU);
   assign table_beat = (state_ff == `PST_ST_TABLE);

   // RL8: stack has no software port
   // RL14: depth fixed at largest variant
   pst_stack u_stack (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .push_i(push),
      .pop_i(pop),
      .push_data_i(push_data),
      .top_o(top),
      .full_o(full)
   );

   always @* begin
      nxt_pc = pc_ff;
      nxt_bank = bank_ff;
      nxt_state = state_ff;
      push = 1'b0;
      pop = 1'b0;
      push_data = {bank_ff, pc_inc};
      take_irq = 1'b0;
      start_table = 1'b0;
      nxt_table_addr = table_addr_ff;
      case (state_ff)
         `PST_ST_RUN: begin
            // RL12: no acknowledge while full
            if (irq_req_i && !full) begin
               take_irq = 1'b1;
               // RL9: interrupt pushes counter
               push = 1'b1;
               push_data = cur_addr;
               // RL4: interrupt loads vector
               {nxt_bank, nxt_pc} = irq_vector_i;
               nxt_state = `PST_ST_DUMMY;
            end else if (instr_valid_i) begin
               nxt_pc = pc_inc;
               case (op_i)
                  `PST_OP_JMP: begin
                     // RL4: jump loads target
                     {nxt_bank, nxt_pc} = {code_bank_select_i, target_i[`PST_PC_W-1:0]};
                     nxt_state = `PST_ST_DUMMY;
                  end
                  `PST_OP_CALL: begin
                     // RL13: push even when full
                     push = 1'b1;
                     // RL2: bank bits above counter
                     {nxt_bank, nxt_pc} = {code_bank_select_i, target_i[`PST_PC_W-1:0]};
                     nxt_state = `PST_ST_DUMMY;
                  end
                  `PST_OP_RET, `PST_OP_IRET: begin
                     // RL10: restore from stack
                     pop = 1'b1;
                     {nxt_bank, nxt_pc} = top;
                     nxt_state = `PST_ST_DUMMY;
                  end
                  `PST_OP_SKIP: begin
                     // RL5: skip over prefetched word
                     if (skip_met_i) begin
                        nxt_pc = pc_ff + 13'h0002;
                        nxt_state = `PST_ST_DUMMY;
                     end
                  end
                  `PST_OP_PCLWR: begin
                     // RL6: upper bits kept
                     nxt_pc = {pc_ff[`PST_PC_W-1:`PST_PAGE_W], pcl_wdata_i};
                     // RL7: dummy prefetch cycle
                     nxt_state = `PST_ST_DUMMY;
                  end
                  default: begin
                     if (is_table) begin
                        start_table = 1'b1;
                        // RL20: high pointer page plus offset, current counter page for the TRDL and TRDFL forms
                        if (is_last) begin
                           nxt_table_addr = {bank_ff, pc_ff[`PST_PC_W-1:`PST_PAGE_W], table_ptr_low_i};
                        end else begin
                           nxt_table_addr = {code_bank_select_i, table_ptr_high_i[4:0], table_ptr_low_i};
                        end
                        // RL19: second cycle reads word
                        nxt_state = `PST_ST_TABLE;
                     end
                  end
               endcase
            end
         end
         `PST_ST_DUMMY: begin
            nxt_state = `PST_ST_RUN;
         end
         `PST_ST_TABLE: begin
            nxt_state = `PST_ST_RUN;
         end
         default: begin
            nxt_state = `PST_ST_RUN;
         end
      endcase
   end

   // sequencing state
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         // RL16: reset vector zero
         pc_ff <= {`PST_PC_W{1'b0}};
         bank_ff <= {`PST_BANK_W{1'b0}};
         state_ff <= `PST_ST_RUN;
         table_addr_ff <= `PST_RESET_VECTOR;
      end else begin
         // RL4: loads arrive through nxt_pc
         pc_ff <= nxt_pc;
         bank_ff <= nxt_bank;
         state_ff <= nxt_state;
         table_addr_ff <= nxt_table_addr;
      end
   end

   // fetch port and status mirrors
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         fetch_addr_o <= `PST_RESET_VECTOR;
         fetch_valid_o <= 1'b0;
         pc_low_byte_o <= 8'h00;
         irq_ack_o <= 1'b0;
         stall_o <= 1'b0;
         stack_full_o <= 1'b0;
      end else begin
         // table beat borrows the fetch port for one cycle
         fetch_addr_o <= (nxt_state == `PST_ST_TABLE) ? nxt_table_addr : {nxt_bank, nxt_pc};
         fetch_valid_o <= 1'b1;
         // RL3: low byte mirror only
         pc_low_byte_o <= nxt_pc[7:0];
         irq_ack_o <= take_irq;
         // RL5: stall marks dummy and table beats
         stall_o <= (nxt_state != `PST_ST_RUN);
         // registered, so one cycle behind the stack count
         stack_full_o <= full;
      end
   end

   // table destination, held through the table beat
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         table_dest_ff <= 8'h00;
         table_sector_ff <= 2'h0;
      end else if (start_table) begin
         table_dest_ff <= dest_addr_i;
         // RL21: short forms force sector zero
         table_sector_ff <= is_far ? dest_sector_i : 2'h0;
      end
   end

   // data memory write port, one-cycle strobe
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         dmem_we_o <= 1'b0;
         dmem_addr_o <= 8'h00;
         dmem_sector_o <= 2'h0;
         dmem_wdata_o <= 8'h00;
      end else if (table_beat) begin
         // RL17: low byte to register
         dmem_we_o <= 1'b1;
         dmem_addr_o <= table_dest_ff;
         dmem_sector_o <= table_sector_ff;
         dmem_wdata_o <= masked_word[7:0];
      end else if (alu_take) begin
         // RL15: result written back
         dmem_we_o <= 1'b1;
         dmem_addr_o <= alu_dest_addr_i;
         dmem_sector_o <= alu_dest_sector_i;
         dmem_wdata_o <= alu_result_i;
      end else begin
         dmem_we_o <= 1'b0;
      end
   end

   // shared high latch: an interrupt handler's read clobbers it
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         table_high_latch_o <= 8'h00;
      end else if (table_beat) begin
         // RL17: high byte to latch
         // RL23: latch replaced each read
         table_high_latch_o <= masked_word[15:8];
      end
   end

   // status flags, only masked bits move
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         status_o <= 4'h0;
      end else if (alu_take) begin
         // RL15: flags updated by mask
         status_o <= (status_o & ~alu_flag_mask_i) | (alu_flags_i & alu_flag_mask_i);
      end
   end
endmodule // pst_sequencer

// ### src/pst_stack.v
// Purpose: return stack holding bank select and program counter values only
// Assumes: push and pop never asserted together
// Notes: overflow wraps, losing the oldest entry
`include "pst_defines.vh"
module pst_stack (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // control
   input wire push_i,
   input wire pop_i,
   input wire [`PST_ADDR_W-1:0] push_data_i,
   // state
   output reg [`PST_ADDR_W-1:0] top_o,
   output wire full_o
);
   reg [`PST_ADDR_W-1:0] mem [0:`PST_STACK_DEPTH-1];
   reg [`PST_SP_W-1:0] sp_ff;
   reg [`PST_CNT_W-1:0] cnt_ff;
   wire [`PST_SP_W-1:0] sp_dec;
   integer i;
   assign sp_dec = sp_ff - 4'h1;
   assign full_o = (cnt_ff == `PST_STACK_DEPTH);
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         // RL11: pointer at top
         sp_ff <= {`PST_SP_W{1'b0}};
         cnt_ff <= {`PST_CNT_W{1'b0}};
         top_o <= `PST_RESET_VECTOR;
         for (i = 0; i < `PST_STACK_DEPTH; i = i + 1) begin
            mem[i] <= `PST_RESET_VECTOR;
         end
      end else if (push_i) begin
         // RL13: wrap overwrites oldest
         mem[sp_ff] <= push_data_i;
         sp_ff <= sp_ff + 4'h1;
         top_o <= push_data_i;
         if (cnt_ff != `PST_STACK_DEPTH) begin
            cnt_ff <= cnt_ff + 5'h01;
         end
      end else if (pop_i) begin
         sp_ff <= sp_dec;
         top_o <= mem[sp_dec - 4'h1];
         if (cnt_ff != {`PST_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 5'h01;
         end
      end
   end
endmodule // pst_stack

// ### verification/pst_prog_mem.sv
// Purpose: program memory and interrupt request model
// Assumes: memory answers in the same cycle
// Notes: word depends on low address byte only
module pst_prog_mem (
   // clock and reset
   input logic clock_i,
   input logic rstn_i,
   // program memory
   input logic [14:0] fetch_addr_i,
   output logic [15:0] prog_word_o,
   // interrupt request
   input logic raise_i,
   input logic ack_i,
   output logic irq_req_o
);
   logic req_ff;
   assign prog_word_o = {fetch_addr_i[7:0] ^ 8'hc3, ~fetch_addr_i[7:0]};
   assign irq_req_o = req_ff;
   always @(posedge clock_i) begin
      if (!rstn_i || ack_i) req_ff <= 1'b0;
      else if (raise_i) req_ff <= 1'b1;
   end
endmodule // pst_prog_mem

// ### verification/pst_sequencer_asserts.sv
// Purpose: port checks for the sequencer
// Assumes: irq_req_i stays low outside interrupt tests
// Notes: timing follows the hand-over walk
`include "pst_defines.vh"
module pst_seq_chk (
   // clock and reset
   input logic clock_i,
   input logic rstn_i,
   // decoder side
   input logic instr_valid_i,
   input logic [3:0] op_i,
   input logic [14:0] target_i,
   input logic skip_met_i,
   input logic [7:0] pcl_wdata_i,
   input logic [7:0] table_ptr_low_i,
   input logic [7:0] table_ptr_high_i,
   input logic [1:0] code_bank_select_i,
   input logic irq_req_i,
   // observed outputs
   input logic [14:0] fetch_addr_o,
   input logic stall_o,
   input logic dmem_we_o,
   input logic [1:0] dmem_sector_o,
   input logic stack_full_o
);
   wire take = instr_valid_i && !stall_o && !irq_req_i;
   wire tbl_take = take && op_i >= `PST_OP_TRD && op_i <= `PST_OP_TRDFL;
   wire [14:0] jmp_a = {code_bank_select_i, target_i[12:0]};
   wire [14:0] tbl_a = {code_bank_select_i, table_ptr_high_i[4:0], table_ptr_low_i};
   wire [6:0] page = fetch_addr_o[14:8];
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_dummy;
      stall_o ##1 !stall_o;
   endsequence
   sequence s_tbl_done;
      stall_o ##[1:2] dmem_we_o ##1 !dmem_we_o;
   endsequence
   property p_inc;
      take && op_i == `PST_OP_SEQ |=> fetch_addr_o == $past(fetch_addr_o) + 15'h1;
   endproperty
   property p_jmp;
      take && op_i == `PST_OP_JMP |=> fetch_addr_o == $past(jmp_a) && stall_o;
   endproperty
   property p_dummy;
      take && (op_i == `PST_OP_PCLWR || (op_i == `PST_OP_SKIP && skip_met_i)) |=> s_dummy;
   endproperty
   property p_page;
      take && op_i == `PST_OP_PCLWR |=> page == $past(page) && fetch_addr_o[7:0] == $past(pcl_wdata_i);
   endproperty
   property p_tbl;
      tbl_take |=> s_tbl_done;
   endproperty
   property p_tbl_addr;
      take && op_i == `PST_OP_TRD |=> fetch_addr_o == $past(tbl_a);
   endproperty
   property p_sector;
      take && (op_i == `PST_OP_TRD || op_i == `PST_OP_TRDL) |=> ##[1:2] (dmem_we_o && dmem_sector_o == 2'h0);
   endproperty
   property p_reset;
      disable iff (1'b0) !rstn_i |=> fetch_addr_o == 15'h0 && !stack_full_o && !stall_o;
   endproperty
   a_inc: assert property (p_inc) else $error("counter did not step by one");
   a_jmp: assert property (p_jmp) else $error("jump target not loaded");
   a_dummy: assert property (p_dummy) else $error("missing single dummy cycle");
   a_page: assert property (p_page) else $error("low byte write left page");
   a_tbl: assert property (p_tbl) else $error("table read not two cycles");
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
   a_sector: assert property (p_sector) else $error("short table read sector");
   a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // pst_seq_chk
bind pst_sequencer pst_seq_chk u_chk (.*);

// ### verification/pst_sequencer_test.sv
// Purpose: directed tests of the sequencer
// Assumes: one instruction per clock, stall waits bounded
// Notes: interrupts kept off during table reads
`include "pst_defines.vh"
module pst_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, rstn_i, instr_valid_i, skip_met_i, irq_raise, irq_req_i, fetch_valid_o;
   logic dmem_we_o, irq_ack_o, stall_o, stack_full_o;
   logic [3:0] op_i, alu_flags_i, alu_flag_mask_i, status_o;
   logic [14:0] target_i, irq_vector_i, fetch_addr_o, pre;
   logic [7:0] pcl_wdata_i, dest_addr_i, alu_result_i, alu_dest_addr_i, table_ptr_low_i, table_ptr_high_i;
   logic [7:0] dmem_addr_o, dmem_wdata_o, pc_low_byte_o, table_high_latch_o;
   logic [1:0] dest_sector_i, alu_dest_sector_i, code_bank_select_i, dmem_sector_o;
   logic [15:0] word_width_mask_i, prog_word_i;
   int num_errors, samples_checked, n;
   pst_sequencer uut (.*);
   pst_prog_mem u_mem (.clock_i(clock_i), .rstn_i(rstn_i), .fetch_addr_i(fetch_addr_o),
      .prog_word_o(prog_word_i), .raise_i(irq_raise), .ack_i(irq_ack_o), .irq_req_o(irq_req_i));
   initial begin
      clock_i = 0;
      forever #5 clock_i = ~clock_i;
   end
   task chk(string name, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task issue(logic [3:0] op, logic [14:0] tgt);
      n = 0;
      while (stall_o !== 1'b0 && n < 8) begin
         @(posedge clock_i);
         #1 n++;
      end
      pre = fetch_addr_o;
      @(posedge clock_i);
      instr_valid_i <= 1'b1;
      op_i <= op;
      target_i <= tgt;
      @(posedge clock_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask
   task t_flow;
      issue(`PST_OP_SEQ, 15'h0);
      chk("inc", fetch_addr_o, pre + 15'h1);
      chk("fvalid1", fetch_valid_o, 1'b1);
      skip_met_i <= 1'b1;
      issue(`PST_OP_SKIP, 15'h0);
      chk("skip", {stall_o, fetch_addr_o}, {1'b1, pre + 15'h2});
      code_bank_select_i <= 2'h3;
      issue(`PST_OP_JMP, 15'h1234);
      chk("jump", fetch_addr_o, 15'h7234);
      chk("pclow", pc_low_byte_o, 8'h34);
      issue(`PST_OP_PCLWR, 15'h0);
      chk("pcwr", {stall_o, fetch_addr_o}, {1'b1, 7'h72, 8'h9e});
   endtask
   task t_table;
      code_bank_select_i <= 2'h0;
      for (int i = 0; i < 4; i++) begin
         table_ptr_low_i <= 8'h06 - i[7:0];
         dest_sector_i <= i[1:0];
         issue(`PST_OP_TRD + i[3:0], 15'h0);
         if (i[0] == 0) chk("taddr", fetch_addr_o, {7'h0f, 8'h06 - i[7:0]});
         n = 0;
         while (dmem_we_o !== 1'b1 && n < 4) begin
            @(posedge clock_i);
            #1 n++;
         end
         chk("tlow", {dmem_addr_o, dmem_wdata_o}, {8'h44, 8'hf9 + i[7:0]});
         chk("thigh", table_high_latch_o, ((8'h06 - i[7:0]) ^ 8'hc3) & 8'h3f);
         chk("tsect", dmem_sector_o, i > 1 ? i[1:0] : 2'h0);
      end
   endtask
   task t_alu;
      issue(`PST_OP_ALU, 15'h0);
      chk("aluwe", {dmem_we_o, dmem_sector_o}, 3'h5);
      chk("aluwr", {dmem_addr_o, dmem_wdata_o}, 16'h215a);
      repeat (2) @(posedge clock_i);
      alu_flags_i <= 4'ha;
      alu_flag_mask_i <= 4'h1;
      chk("flags", status_o, 4'h5);
      issue(`PST_OP_ALU, 15'h0);
      repeat (2) @(posedge clock_i);
      chk("flagmask", status_o, 4'h4);
   endtask
   task t_stack;
      logic [14:0] ret_pc;
      issue(`PST_OP_CALL, 15'h0100);
      ret_pc = pre + 15'h1;
      issue(`PST_OP_RET, 15'h0);
      chk("ret", fetch_addr_o, ret_pc);
      repeat (17) issue(`PST_OP_CALL, 15'h0200);
      chk("full", {stack_full_o, fetch_addr_o}, {1'b1, 15'h0200});
      // a request while the stack is full gets no acknowledge
      irq_raise <= 1'b1;
      @(posedge clock_i);
      irq_raise <= 1'b0;
      n = 0;
      repeat (6) @(posedge clock_i) n += irq_ack_o;
      chk("held", n, 0);
      issue(`PST_OP_RET, 15'h0);
      n = 0;
      repeat (8) @(posedge clock_i) n += irq_ack_o;
      chk("served", n, 1);
      chk("vector", fetch_addr_o, 15'h0040);
      issue(`PST_OP_IRET, 15'h0);
      chk("iret", fetch_addr_o, 15'h0201);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {rstn_i, instr_valid_i, skip_met_i, irq_raise, op_i, target_i} = '0;
      irq_vector_i = 15'h0040;
      {dest_addr_i, dest_sector_i, alu_dest_addr_i, alu_dest_sector_i} = {8'h44, 2'h0, 8'h21, 2'h1};
      {alu_result_i, alu_flags_i, alu_flag_mask_i, pcl_wdata_i} = {8'h5a, 4'h5, 4'hf, 8'h9e};
      {table_ptr_low_i, table_ptr_high_i, code_bank_select_i, word_width_mask_i} = {16'h060f, 2'h0, 16'h3fff};
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      #1 chk("rst", {stall_o, fetch_addr_o}, 16'h0);
      chk("rstfull", stack_full_o, 1'b0);
      chk("fvalid0", fetch_valid_o, 1'b0);
      t_flow;
      t_table;
      t_alu;
      t_stack;
      print_verdict;
   end
   initial begin
      #200000;
      num_errors++;
      print_verdict;
   end
endmodule // pst_sequencer_test
